// [design/eoc_ext_osc_ctrl.sv]
// Summary of operation
// - One 8-bit control register at address 0xb1, all bits zero on reset.
// - Bit 7 is read-only crystal valid: 0 unused or unstable, 1 stable.
// - Valid flag only meaningful in crystal modes (mode 11x).
// - Bits 6:4 are a read/write oscillator mode field.
// - Bit 3 unused: reads zero, writes ignored.
// - Bits 2:0 read/write frequency code; crystal bands rise with code.
// - After crystal enable, valid stays low for an amplitude settling time.
// - Crystal mode uses both crystal pins; other enabled modes only the output pin, off modes (00x) neither.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module eoc_ext_osc_ctrl
  import eoc_pkg::*;
#(
  parameter int SETTLE_CYCLES = EOC_SETTLE_CYCLES,
  parameter int STABLE_CYCLES = EOC_STABLE_CYCLES
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Analog front end
  input  wire logic       amp_ok,
  input  wire logic       osc_tick,
  // Oscillator drive controls
  output logic            osc_enable,
  output logic            xtal_drive_en,
  output logic      [2:0] drive_code,
  output logic            crystal_in_pin_used,
  output logic            crystal_out_pin_used,
  output logic            ext_clk_tick,
  // Interrupt
  output logic            irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_xtal(input logic [2:0] m);
    return m[2] & m[1];
  endfunction

  function automatic logic is_off(input logic [2:0] m);
    return ~m[2] & ~m[1];
  endfunction

  function automatic logic is_div2(input logic [2:0] m);
    return (m == EOC_MODE_DIG_DIV2) || (m == EOC_MODE_XTAL_DIV2);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [2:0]      ext_osc_mode_field;
  logic [2:0]      ext_osc_freq_code;
  logic            crystal_valid_flag;
  logic [7:0]      irq_status;
  logic [7:0]      irq_mask;
  eoc_xtal_state_t xstate;
  eoc_xtal_state_t next_xstate;
  logic [31:0]     settle_cnt;
  logic [31:0]     stable_cnt;
  logic            valid_q;
  logic [7:0]      ext_osc_control_reg;
  logic [7:0]      events;
  logic            wr_ctrl;
  logic            settle_done;
  logic            stable_done;
  logic            div_tick;

  assign wr_ctrl = reg_wr && (reg_addr == EOC_ADDR_CONTROL);
  assign settle_done = (settle_cnt >= 32'(SETTLE_CYCLES));
  assign stable_done = (stable_cnt >= 32'(STABLE_CYCLES));

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Reset clears every field; bit 3 has no storage so writes vanish
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_osc_mode_field <= EOC_CONTROL_RESET[EOC_MODE_MSB:EOC_MODE_LSB];
      ext_osc_freq_code  <= EOC_CONTROL_RESET[EOC_FREQ_MSB:EOC_FREQ_LSB];
    end else if (wr_ctrl) begin
      ext_osc_mode_field <= reg_wdata[EOC_MODE_MSB:EOC_MODE_LSB];
      ext_osc_freq_code  <= reg_wdata[EOC_FREQ_MSB:EOC_FREQ_LSB];
    end
  end

  // Read image: valid in bit 7, unused bit 3 forced to zero
  always_comb begin
    ext_osc_control_reg = EOC_CONTROL_RESET;
    ext_osc_control_reg[EOC_VALID_BIT] = crystal_valid_flag;
    ext_osc_control_reg[EOC_MODE_MSB:EOC_MODE_LSB] = ext_osc_mode_field;
    ext_osc_control_reg[EOC_FREQ_MSB:EOC_FREQ_LSB] = ext_osc_freq_code;
  end

  // ----------------------------------------------------------------
  // Crystal qualifier
  // ----------------------------------------------------------------
  // Leaving crystal mode drops back to idle at once, so the flag can
  // never show a stale stable state from an earlier start.
  always_comb begin
    next_xstate = xstate;
    unique case (xstate)
      EOC_XS_IDLE: begin
        if (is_xtal(ext_osc_mode_field)) begin
          next_xstate = EOC_XS_SETTLE;
        end
      end
      EOC_XS_SETTLE: begin
        if (!is_xtal(ext_osc_mode_field)) begin
          next_xstate = EOC_XS_IDLE;
        end else if (settle_done && stable_done) begin
          next_xstate = EOC_XS_VALID;
        end
      end
      EOC_XS_VALID: begin
        if (!is_xtal(ext_osc_mode_field)) begin
          next_xstate = EOC_XS_IDLE;
        end else if (!amp_ok) begin
          next_xstate = EOC_XS_SETTLE;
        end
      end
      default: begin
        next_xstate = EOC_XS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xstate <= EOC_XS_IDLE;
    end else begin
      xstate <= next_xstate;
    end
  end

  // Settling time runs from crystal enable; saturates to stay bounded
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt <= 32'h0;
    end else if (xstate == EOC_XS_IDLE) begin
      settle_cnt <= 32'h0;
    end else if (!settle_done) begin
      settle_cnt <= settle_cnt + 32'h1;
    end
  end

  // Amplitude must hold good for a run of cycles; filters detector chatter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stable_cnt <= 32'h0;
    end else if (xstate == EOC_XS_IDLE || !amp_ok) begin
      stable_cnt <= 32'h0;
    end else if (!stable_done) begin
      stable_cnt <= stable_cnt + 32'h1;
    end
  end

  // Flag is zero whenever the crystal is not selected
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crystal_valid_flag <= 1'b0;
    end else begin
      crystal_valid_flag <= (next_xstate == EOC_XS_VALID);
    end
  end

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  // Pin usage follows the mode; crystal needs both pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_enable           <= 1'b0;
      xtal_drive_en        <= 1'b0;
      drive_code           <= 3'h0;
      crystal_in_pin_used  <= 1'b0;
      crystal_out_pin_used <= 1'b0;
    end else begin
      osc_enable           <= ~is_off(ext_osc_mode_field);
      xtal_drive_en        <= is_xtal(ext_osc_mode_field);
      drive_code           <= ext_osc_freq_code;
      crystal_in_pin_used  <= is_xtal(ext_osc_mode_field);
      crystal_out_pin_used <= ~is_off(ext_osc_mode_field);
    end
  end

  // Optional divide-by-two of the oscillator tick
  eoc_clk_div2 u_div2 (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick_in  (osc_tick & ~is_off(ext_osc_mode_field)),
    .div_en   (is_div2(ext_osc_mode_field)),
    .tick_out (div_tick)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clk_tick <= 1'b0;
    end else begin
      ext_clk_tick <= div_tick;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= crystal_valid_flag;
    end
  end

  always_comb begin
    events = 8'h00;
    events[EOC_IRQ_VALID_RISE] = crystal_valid_flag & ~valid_q;
    events[EOC_IRQ_VALID_LOSS] = ~crystal_valid_flag & valid_q;
    events[EOC_IRQ_MODE_CHANGE] = wr_ctrl &&
      (reg_wdata[EOC_MODE_MSB:EOC_MODE_LSB] != ext_osc_mode_field);
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= EOC_IRQ_RESET;
    end else begin
      if (reg_wr && reg_addr == EOC_ADDR_IRQ_STATUS) begin
        irq_status <= ((irq_status & ~reg_wdata) | events) & EOC_IRQ_USED;
      end else begin
        irq_status <= (irq_status | events) & EOC_IRQ_USED;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask <= EOC_IRQ_RESET;
    end else if (reg_wr && reg_addr == EOC_ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata & EOC_IRQ_USED;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stands only the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= EOC_READ_UNMAPPED;
    end else if (reg_rd) begin
      unique case (reg_addr)
        EOC_ADDR_CONTROL:    reg_rdata <= ext_osc_control_reg;
        EOC_ADDR_IRQ_STATUS: reg_rdata <= irq_status;
        EOC_ADDR_IRQ_MASK:   reg_rdata <= irq_mask;
        default:             reg_rdata <= EOC_READ_UNMAPPED;
      endcase
    end else begin
      reg_rdata <= EOC_READ_UNMAPPED;
    end
  end

endmodule : eoc_ext_osc_ctrl
`default_nettype wire

// [design/eoc_pkg.sv]
package eoc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EOC_ADDR_CONTROL = 8'hb1;
  localparam logic [7:0] EOC_ADDR_IRQ_STATUS = 8'hb2;
  localparam logic [7:0] EOC_ADDR_IRQ_MASK = 8'hb3;
  localparam logic [7:0] EOC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] EOC_IRQ_RESET = 8'h00;
  localparam logic [7:0] EOC_READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the control register
  // ----------------------------------------------------------------
  localparam int EOC_VALID_BIT = 7;
  localparam int EOC_MODE_MSB = 6;
  localparam int EOC_MODE_LSB = 4;
  localparam int EOC_FREQ_MSB = 2;
  localparam int EOC_FREQ_LSB = 0;

  // Interrupt status bits
  localparam int EOC_IRQ_VALID_RISE = 0;
  localparam int EOC_IRQ_VALID_LOSS = 1;
  localparam int EOC_IRQ_MODE_CHANGE = 2;
  localparam logic [7:0] EOC_IRQ_USED = 8'h07;

  // ----------------------------------------------------------------
  // Oscillator mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] EOC_MODE_OFF0 = 3'h0;
  localparam logic [2:0] EOC_MODE_OFF1 = 3'h1;
  localparam logic [2:0] EOC_MODE_DIG = 3'h2;
  localparam logic [2:0] EOC_MODE_DIG_DIV2 = 3'h3;
  localparam logic [2:0] EOC_MODE_RC = 3'h4;
  localparam logic [2:0] EOC_MODE_CAP = 3'h5;
  localparam logic [2:0] EOC_MODE_XTAL = 3'h6;
  localparam logic [2:0] EOC_MODE_XTAL_DIV2 = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EOC_CLK_HZ = 10_000_000;
  localparam int EOC_SETTLE_US = 1000;
  localparam int EOC_SETTLE_CYCLES = EOC_SETTLE_US * (EOC_CLK_HZ / 1_000_000);
  localparam int EOC_STABLE_CYCLES = 16;

  // Crystal qualifier states
  typedef enum logic [2:0] {
    EOC_XS_IDLE   = 3'b001,
    EOC_XS_SETTLE = 3'b010,
    EOC_XS_VALID  = 3'b100
  } eoc_xtal_state_t;

endpackage : eoc_pkg

// [design/eoc_clk_div2.sv]
`timescale 1ns/100ps
`default_nettype none

// Toggle-based divide-by-two enable for the selected oscillator tick.
module eoc_clk_div2
  import eoc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Tick input and division select
  input  wire logic tick_in,
  input  wire logic div_en,
  // Tick output
  output logic      tick_out
);

  logic phase;

  // ----------------------------------------------------------------
  // Phase toggles on each input tick; passes every second one
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 1'b0;
    end else if (!div_en) begin
      phase <= 1'b0;
    end else if (tick_in) begin
      phase <= ~phase;
    end
  end

  // Registered so the output is glitch free
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & (~div_en | phase);
    end
  end

endmodule : eoc_clk_div2
`default_nettype wire

// [bench/eoc_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the oscillator control block
// ----------------------------------------------------------------
module eoc_props
  import eoc_pkg::*;
#(
  parameter int SETTLE_CYCLES = EOC_SETTLE_CYCLES,
  parameter int STABLE_CYCLES = EOC_STABLE_CYCLES
)
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Front end and drive
  input wire logic       amp_ok,
  input wire logic       osc_tick,
  input wire logic       osc_enable,
  input wire logic       xtal_drive_en,
  input wire logic [2:0] drive_code,
  input wire logic       crystal_in_pin_used,
  input wire logic       crystal_out_pin_used,
  input wire logic       ext_clk_tick,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int         xtal_cnt;
  logic [2:0] mask_q;
  // Age of crystal drive and a mirror of the mask writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_cnt <= 0;
      mask_q   <= 3'h0;
    end else begin
      xtal_cnt <= xtal_drive_en ? xtal_cnt + 1 : 0;
      if (reg_wr && reg_addr == 8'hb3) mask_q <= reg_wdata[2:0];
    end
  end
  sequence s_ctrl_rd;
    reg_rd && reg_addr == 8'hb1;
  endsequence
  // Gap after the write lets a one or two stage output land
  sequence s_ctrl_wr;
    reg_wr && reg_addr == 8'hb1 ##1 !reg_wr [*2];
  endsequence
  property p_idle_rdata;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("read data not zero outside a read");
  property p_unmapped;
    reg_rd && (reg_addr < 8'hb1 || reg_addr > 8'hb3) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_unused_bit;
    s_ctrl_rd |=> !reg_rdata[3];
  endproperty
  a_unused_bit: assert property (p_unused_bit)
    else $error("unused control bit reads one");
  property p_valid_off;
    !xtal_drive_en [*3] ##0 s_ctrl_rd |=> !reg_rdata[7];
  endproperty
  a_valid_off: assert property (p_valid_off)
    else $error("valid flag set outside crystal mode");
  property p_valid_settle;
    s_ctrl_rd ##1 reg_rdata[7] |-> xtal_cnt >= SETTLE_CYCLES - 2;
  endproperty
  a_valid_settle: assert property (p_valid_settle)
    else $error("valid flag set before settling");
  property p_amp_loss;
    !amp_ok [*2] ##1 s_ctrl_rd |=> !reg_rdata[7];
  endproperty
  a_amp_loss: assert property (p_amp_loss)
    else $error("valid flag kept without amplitude");
  property p_mode_drive;
    s_ctrl_wr |-> xtal_drive_en == ($past(reg_wdata[6:5], 2) == 2'b11)
      && crystal_in_pin_used == xtal_drive_en;
  endproperty
  a_mode_drive: assert property (p_mode_drive)
    else $error("crystal drive does not follow mode");
  property p_enable;
    s_ctrl_wr |-> osc_enable == ($past(reg_wdata[6:5], 2) != 2'b00)
      && crystal_out_pin_used == osc_enable;
  endproperty
  a_enable: assert property (p_enable)
    else $error("oscillator enable does not follow mode");
  property p_code;
    s_ctrl_wr |-> drive_code == $past(reg_wdata[2:0], 2);
  endproperty
  a_code: assert property (p_code)
    else $error("drive code does not follow write");
  property p_no_tick;
    !osc_enable [*4] |-> !ext_clk_tick;
  endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("clock tick while oscillator off");
  property p_irq_mask;
    (mask_q == 3'h0) [*3] |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised while fully masked");
endmodule // eoc_props

bind eoc_ext_osc_ctrl eoc_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .STABLE_CYCLES(STABLE_CYCLES)
) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .amp_ok(amp_ok), .osc_tick(osc_tick),
  .osc_enable(osc_enable), .xtal_drive_en(xtal_drive_en),
  .drive_code(drive_code), .crystal_in_pin_used(crystal_in_pin_used),
  .crystal_out_pin_used(crystal_out_pin_used),
  .ext_clk_tick(ext_clk_tick), .irq(irq)
);
`default_nettype wire

// [bench/eoc_osc_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// External oscillator and amplitude detector model
// ----------------------------------------------------------------
module eoc_osc_model
  import eoc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Drive from the block and fault command
  input  wire logic osc_enable,
  input  wire logic xtal_drive_en,
  input  wire logic amp_fail,
  // Oscillator outputs
  output logic      amp_ok,
  output logic      osc_tick
);
  logic [1:0] phase;
  int         bias;
  // Ticks every third cycle, silent while undriven
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase    <= 2'h0;
      osc_tick <= 1'b0;
    end else begin
      phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      osc_tick <= osc_enable && phase == 2'h2;
    end
  end
  // Amplitude builds a few cycles after crystal drive starts
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bias   <= 0;
      amp_ok <= 1'b0;
    end else begin
      bias   <= xtal_drive_en ? bias + 1 : 0;
      amp_ok <= xtal_drive_en && bias >= 5 && !amp_fail;
    end
  end
endmodule // eoc_osc_model
`default_nettype wire

// [bench/external_oscillator_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module external_oscillator_control_bench
  import eoc_pkg::*;
;
  logic       core_clk, sys_rst, reg_wr, reg_rd, amp_fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, w;
  logic       amp_ok, osc_tick, osc_en, xtal_en, in_used, out_used;
  logic       ext_tick, irq;
  logic [2:0] drive_code;
  int         fail_count, compares, cyc, n, cnt, exp_ctrl;
  // Short settle counts keep the run brief
  localparam int TB_SETTLE = 20;
  eoc_ext_osc_ctrl #(.SETTLE_CYCLES(TB_SETTLE), .STABLE_CYCLES(4)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .amp_ok(amp_ok), .osc_tick(osc_tick),
    .osc_enable(osc_en), .xtal_drive_en(xtal_en), .drive_code(drive_code),
    .crystal_in_pin_used(in_used), .crystal_out_pin_used(out_used),
    .ext_clk_tick(ext_tick), .irq(irq));
  eoc_osc_model osc_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .osc_enable(osc_en),
    .xtal_drive_en(xtal_en), .amp_fail(amp_fail), .amp_ok(amp_ok),
    .osc_tick(osc_tick));
  // Clock source
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    compares++;
    if (seen !== expd) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  task automatic report_and_stop;
    $display("Counts: compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bus cycles; the model follows every control write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == 8'hb1) exp_ctrl = int'(d & 8'h77);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    {sys_rst, amp_fail} = 2'b11;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    {fail_count, compares, cyc, exp_ctrl} = '0;
    void'($urandom(32'h35a327cb));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 4; n++) begin
      rd(8'hb0 + n[7:0]);
      check(rv, 8'h00);
    end
    $display("test reset values done");
    // Every mode with random code and junk in bits 7 and 3
    for (n = 0; n < 8; n++) begin
      w = 8'($urandom);
      w[6:4] = n[2:0];
      wr(8'hb1, w);
      rd(8'hb1);
      check(rv, exp_ctrl[7:0]);
      check({7'h0, osc_en}, {7'h0, n > 1});
      check({6'h0, xtal_en, in_used}, {6'h0, {2{n > 5}}});
      check({7'h0, out_used}, {7'h0, n > 1});
      check({5'h0, drive_code}, {5'h0, w[2:0]});
    end
    $display("test modes done");
    for (n = 2; n < 4; n++) begin
      wr(8'hb1, {1'b0, n[2:0], 4'h0});
      repeat (10) @(posedge core_clk);
      cnt = 0;
      repeat (60) begin
        @(posedge core_clk);
        #1 cnt += int'(ext_tick);
      end
      check(cnt[7:0], (n == 2) ? 8'h14 : 8'h0a);
    end
    $display("test clock division done");
    wr(8'hb2, 8'hff);
    wr(8'hb3, 8'h04);
    // RC network at 100 kHz takes the third band, code 010
    wr(8'hb1, 8'h42);
    repeat (3) @(posedge core_clk);
    #1 check({7'h0, irq}, 8'h01);
    rd(8'hb2);
    check(rv, 8'h04);
    wr(8'hb3, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 check({7'h0, irq}, 8'h00);
    wr(8'hb2, 8'h04);
    wr(8'hb3, 8'h04);
    rd(8'hb2);
    check(rv, 8'h00);
    check({7'h0, irq}, 8'h00);
    $display("test interrupt done");
    // Capacitor mode, code 011 picked for a K factor of 22
    wr(8'hb1, 8'h53);
    rd(8'hb1);
    check(rv, 8'h53);
    check({5'h0, drive_code}, 8'h03);
    // Start-up: enable, wait out the settling, poll, then switch
    amp_fail <= 1'b0;
    wr(8'hb1, 8'h67);
    rd(8'hb1);
    check(rv, 8'h67);
    // Amplitude is good well before this read; the flag must stay low
    repeat (TB_SETTLE - 6) @(posedge core_clk);
    rd(8'hb1);
    check(rv, 8'h67);
    repeat (4) @(posedge core_clk);
    n = 0;
    while (rv[7] !== 1'b1 && n < 40) begin
      rd(8'hb1);
      n++;
    end
    // The system clock may move to the crystal only past here
    // A missing clock detector is optional and lives elsewhere
    check({7'h0, rv[7]}, 8'h01);
    wr(8'hb1, 8'h60);
    rd(8'hb1);
    check(rv, 8'he0);
    amp_fail <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(8'hb1);
    check(rv, 8'h60);
    amp_fail <= 1'b0;
    wr(8'hb1, 8'h47);
    repeat (4) @(posedge core_clk);
    rd(8'hb1);
    check(rv, 8'h47);
    // Valid rise, valid loss and mode changes all left sticky bits
    rd(8'hb2);
    check(rv, 8'h07);
    check({7'h0, irq}, 8'h01);
    $display("test crystal start done");
    report_and_stop;
  end
endmodule // external_oscillator_control_bench
`default_nettype wire
